//--- core/word_reg_regs.vh
`ifndef WORD_REG_REGS_VH
`define WORD_REG_REGS_VH
`define WR_IDX_W 8
`define WR_RETAIN_LO 8'h65
`define WR_RETAIN_HI 8'hF0
`define WR_AQ_MODE0 8'hD0
`define WR_AQ_LVL0 8'hD4
`define WR_HIDE 8'hD8
`define WR_PULSE 8'hC9
`define WR_TEMP0 8'hCA
`define WR_SUNRISE 8'hCE
`define WR_SUNSET 8'hCF
`define WR_RTC0 8'hD9
`define WR_AUX 8'hE0
`define WR_STBY0 8'hE1
`define WR_STBY2 8'hE3
`define WR_EXTS0 8'hE4
`define WR_AIN0 8'hE8
`define WR_EXTR0 8'hEC
`define WR_LVL_MAX 16'h0FFF
`define WR_SCALED_MAX 16'h07D0
`define WR_MODE_MAX 16'h0003
// Analog output scaling: level * 1000 / 4095
`define WR_AOUT_SCALE 28'h00003E8
`define WR_AOUT_DIV 28'h0000FFF
// Control word at byte 0x400: bit0 signed, bit1 running
`define WR_CTRL_ADDR 12'h400
`define WR_CTRL_SIGNED 0
`define WR_CTRL_RUN 1
// Word i at byte 4*i
`define WR_ADDR_LSB 2
`endif

//--- core/word_register_file.v
`timescale 1ns/1ns
`include "word_reg_regs.vh"
module word_register_file #(
    parameter NUM_WORDS = 256
) (
    input wire mclk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire preset_load,
    input wire [7:0] preset_index,
    input wire preset_from_block,
    input wire [15:0] preset_const,
    input wire [15:0] preset_block_value,
    input wire power_restore,
    input wire [15:0] pulse_count,
    input wire thermo_present,
    input wire [63:0] thermo_fahrenheit,
    input wire [15:0] sunrise_time,
    input wire [15:0] sunset_time,
    input wire [111:0] clock_fields,
    input wire aux_coil_set,
    input wire [15:0] aux_coil_number,
    input wire ext_analog_present,
    input wire [63:0] ext_analog_scaled,
    input wire [63:0] ext_analog_raw,
    input wire [3:0] onboard_analog_present,
    input wire [63:0] onboard_analog,
    output reg signed_format,
    output reg program_running,
    output reg [7:0] analog_output_mode,
    output reg [63:0] analog_output_channel,
    output reg [15:0] io_display_hiding
);
    reg [15:0] word_q [0:NUM_WORDS-1];
    // Retained copy models battery-backed storage; survives rst_n
    reg [15:0] keep_q [0:NUM_WORDS-1];
    reg [1:0] restore_sync_q;
    reg restore_seen_q;
    wire restore_pulse = restore_sync_q[1] & ~restore_seen_q;
    wire apb_wr = psel & penable & pwrite;
    wire [7:0] widx = paddr[9:2];
    wire ctrl_hit = (paddr == `WR_CTRL_ADDR);
    wire map_hit = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);

    function in_range;
        input [7:0] i;
        input [7:0] lo;
        input [7:0] hi;
        in_range = (i >= lo) && (i <= hi);
    endfunction

    // Live feed for special words; returns 1 when hardware owns word
    function hw_owned;
        input [7:0] i;
        hw_owned = (i == `WR_PULSE)
            || (in_range(i, `WR_TEMP0, `WR_TEMP0 + 8'h03)
                && thermo_present)
            || (i == `WR_SUNRISE) || (i == `WR_SUNSET)
            || in_range(i, `WR_RTC0, `WR_RTC0 + 8'h06)
            || (in_range(i, `WR_EXTS0, `WR_EXTS0 + 8'h03)
                && ext_analog_present)
            || (in_range(i, `WR_AIN0, `WR_AIN0 + 8'h03)
                && onboard_analog_present[i[1:0]])
            || (in_range(i, `WR_EXTR0, `WR_EXTR0 + 8'h03)
                && ext_analog_present);
    endfunction

    function [15:0] hw_value;
        input [7:0] i;
        reg [1:0] k;
        begin
            k = i[1:0];
            hw_value = 16'h0000;
            if (i == `WR_PULSE)
                hw_value = pulse_count;
            else if (in_range(i, `WR_TEMP0, `WR_TEMP0 + 8'h03))
                hw_value = thermo_fahrenheit[16*(i - `WR_TEMP0) +: 16];
            else if (i == `WR_SUNRISE)
                hw_value = sunrise_time;
            else if (i == `WR_SUNSET)
                hw_value = sunset_time;
            else if (in_range(i, `WR_RTC0, `WR_RTC0 + 8'h06))
                // Year first, second last
                hw_value = clock_fields[16*(i - `WR_RTC0) +: 16];
            else if (in_range(i, `WR_EXTS0, `WR_EXTS0 + 8'h03))
                hw_value = (ext_analog_scaled[16*k +: 16] > `WR_SCALED_MAX)
                    ? `WR_SCALED_MAX : ext_analog_scaled[16*k +: 16];
            else if (in_range(i, `WR_AIN0, `WR_AIN0 + 8'h03))
                hw_value = (onboard_analog[16*k +: 16] > `WR_LVL_MAX)
                    ? `WR_LVL_MAX : onboard_analog[16*k +: 16];
            else if (in_range(i, `WR_EXTR0, `WR_EXTR0 + 8'h03))
                hw_value = (ext_analog_raw[16*k +: 16] > `WR_LVL_MAX)
                    ? `WR_LVL_MAX : ext_analog_raw[16*k +: 16];
        end
    endfunction

    wire [15:0] preset_val = preset_from_block
        ? preset_block_value : preset_const;

    genvar g;
    generate
        for (g = 0; g < NUM_WORDS; g = g + 1) begin : gen_word
            localparam [31:0] IDX_FULL = g;
            wire [7:0] gi = IDX_FULL[7:0];
            wire retained = in_range(gi, `WR_RETAIN_LO, `WR_RETAIN_HI);
            wire reserved = in_range(gi, `WR_STBY0, `WR_STBY2) ||
                (gi == `WR_RETAIN_HI);
            reg [15:0] word_d;
            reg word_we;
            always @* begin
                word_we = 1'b1;
                word_d = word_q[g];
                if (preset_load && preset_index == gi) begin
                    // Coil wins even over special meaning
                    word_d = preset_val;
                end else if (hw_owned(gi)) begin
                    word_d = hw_value(gi);
                end else if (gi == `WR_AUX && program_running &&
                             aux_coil_set) begin
                    word_d = aux_coil_number;
                end else if (apb_wr && map_hit && widx == gi &&
                             !reserved) begin
                    // Full 16 bits stored; format only interprets
                    word_d = pwdata[15:0];
                end else begin
                    word_we = 1'b0;
                end
            end
            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    word_q[g] <= 16'h0000;
                end else if (restore_pulse && retained) begin
                    word_q[g] <= keep_q[g];
                end else if (word_we) begin
                    word_q[g] <= word_d;
                end
            end
            // No reset; follows real updates only, so cleared words
            // after reset never wipe what must survive
            always @(posedge mclk) begin
                if (word_we && !restore_pulse)
                    keep_q[g] <= word_d;
            end
        end
    endgenerate

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            restore_sync_q <= 2'b00;
            restore_seen_q <= 1'b0;
        end else begin
            restore_sync_q <= {restore_sync_q[0], power_restore};
            restore_seen_q <= restore_sync_q[1];
        end
    end

    // Zero-wait APB: pready one cycle after setup
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            signed_format <= 1'b0;
            program_running <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~(map_hit | ctrl_hit);
            if (psel && !penable && !pwrite) begin
                if (ctrl_hit)
                    prdata <= {30'h0, program_running,
                               signed_format};
                else if (map_hit)
                    // Signed format sign-extends into upper bits
                    prdata <= {{16{signed_format & word_q[widx][15]}},
                               word_q[widx]};
                else
                    prdata <= 32'h00000000;
            end
            if (apb_wr && pready && ctrl_hit) begin
                signed_format <= pwdata[`WR_CTRL_SIGNED];
                program_running <= pwdata[`WR_CTRL_RUN];
            end
        end
    end

    // Analog outputs: level / 4.095 == level*1000/4095, truncated
    wire [7:0] mode_next;
    wire [63:0] aout_next;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_aout
            wire [15:0] lvl_raw = word_q[`WR_AQ_LVL0 + g];
            wire [15:0] lvl = (lvl_raw > `WR_LVL_MAX)
                ? `WR_LVL_MAX : lvl_raw;
            wire [27:0] prod = lvl * `WR_AOUT_SCALE;
            wire [27:0] quot = prod / `WR_AOUT_DIV;
            wire [15:0] mode_word = word_q[`WR_AQ_MODE0 + g];
            assign mode_next[2*g +: 2] = mode_word[1:0];
            // Quotient never exceeds 1000, so 16 bits hold it
            assign aout_next[16*g +: 16] = quot[15:0];
        end
    endgenerate

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            analog_output_mode <= 8'h00;
            analog_output_channel <= 64'h0;
            io_display_hiding <= 16'h0000;
        end else begin
            io_display_hiding <= word_q[`WR_HIDE];
            analog_output_mode <= mode_next;
            analog_output_channel <= aout_next;
        end
    end
endmodule // word_register_file

//--- verif/word_reg_checker_assertions.sv
`timescale 1ns/1ns
module word_reg_checker (
    input wire mclk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire preset_load,
    input wire [7:0] preset_index,
    input wire preset_from_block,
    input wire [15:0] preset_const,
    input wire [15:0] pulse_count,
    input wire signed_format,
    input wire [7:0] analog_output_mode,
    input wire [63:0] analog_output_channel,
    input wire [15:0] io_display_hiding
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Three steady cycles cover either output latency
    sequence s_load(idx);
        (preset_load && !preset_from_block && preset_index == idx
            && $stable(preset_const))[*3];
    endsequence
    AST_READY: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_ACCESS: assert property (pready |-> psel && penable)
        else $error("answer outside access");
    AST_ERR: assert property (pslverr |-> pready)
        else $error("error without answer");
    AST_ONE: assert property (pready |=> !pready)
        else $error("answer held too long");
    AST_FORMAT: assert property (pready && pwrite && paddr == 12'h400
        |=> signed_format == $past(pwdata[0])) else $error("format lost");
    AST_HIDE: assert property (s_load(8'hD8)
        |-> io_display_hiding == preset_const) else $error("hide wrong");
    AST_MODE: assert property (s_load(8'hD0)
        |-> analog_output_mode[1:0] == preset_const[1:0])
        else $error("mode wrong");
    AST_LEVEL: assert property (analog_output_channel[15:0] <= 16'h03E8)
        else $error("output above full scale");
    AST_PULSE: assert property (psel && !penable && !pwrite
        && paddr == 12'h324 && $stable(pulse_count)
        |=> prdata[15:0] == pulse_count) else $error("pulse count wrong");
endmodule // word_reg_checker
bind word_register_file word_reg_checker mon (.*);

//--- verif/relay_engine.sv
`timescale 1ns/1ns
module relay_engine (
    input wire present,
    output wire [15:0] pulse_count,
    output wire [63:0] thermo_fahrenheit,
    output wire [15:0] sunrise_time,
    output wire [15:0] sunset_time,
    output wire [111:0] clock_fields,
    output wire [15:0] aux_coil_number,
    output wire [63:0] ext_analog_scaled,
    output wire [63:0] ext_analog_raw,
    output wire [63:0] onboard_analog,
    output wire thermo_present,
    output wire ext_analog_present,
    output wire [3:0] onboard_analog_present
);
    // Every feed carries its own word index, so a misroute shows
    function [63:0] quad(input [7:0] b);
        quad = {8'h00, b + 8'h03, 8'h00, b + 8'h02, 8'h00, b + 8'h01, 8'h00, b};
    endfunction
    assign pulse_count = 16'h00C9;
    assign thermo_fahrenheit = quad(8'hCA);
    assign sunrise_time = 16'h00CE;
    assign sunset_time = 16'h00CF;
    assign clock_fields = {8'h00, 8'hDF, 8'h00, 8'hDE, 8'h00, 8'hDD,
        quad(8'hD9)};
    assign aux_coil_number = 16'h00E0;
    assign ext_analog_scaled = quad(8'hE4);
    assign ext_analog_raw = quad(8'hEC);
    assign onboard_analog = quad(8'hE8);
    assign thermo_present = present;
    assign ext_analog_present = present;
    assign onboard_analog_present = {4{present}};
endmodule // relay_engine

//--- verif/word_register_file_special_map_bench.sv
`timescale 1ns/1ns
module word_register_file_special_map_bench;
    logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic preset_load = 0, preset_from_block = 0, power_restore = 0;
    logic aux_coil_set = 0, present = 0, rerr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rdata;
    logic [7:0] preset_index = 0;
    logic [15:0] preset_const = 0, preset_block_value = 0;
    logic [7:0] ids [11] = '{8'hC9, 8'hCA, 8'hCD, 8'hCE, 8'hCF, 8'hD9,
        8'hDF, 8'hE0, 8'hE4, 8'hE8, 8'hEF};
    int error_cnt, compares, cyc;
    wire [31:0] prdata;
    wire pready, pslverr, signed_format, program_running;
    wire thermo_present, ext_analog_present;
    wire [3:0] onboard_analog_present;
    wire [7:0] analog_output_mode;
    wire [15:0] io_display_hiding, pulse_count, sunrise_time, sunset_time;
    wire [15:0] aux_coil_number;
    wire [63:0] analog_output_channel, thermo_fahrenheit, onboard_analog;
    wire [63:0] ext_analog_scaled, ext_analog_raw;
    wire [111:0] clock_fields;
    word_register_file dut (.*);
    relay_engine eng (.*);
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task report_and_stop();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(string nm, logic [31:0] s, logic [31:0] e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask
    // Two idle cycles let registered outputs settle before checks
    task apb(logic w, logic [11:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task wr(logic [7:0] i, logic [15:0] d);
        apb(1'b1, {2'b00, i, 2'b00}, {16'h0000, d});
    endtask
    task rd(logic [7:0] i);
        apb(1'b0, {2'b00, i, 2'b00}, 32'h0);
    endtask
    task load(logic [7:0] i, logic b, logic [15:0] c);
        preset_index <= i;
        preset_from_block <= b;
        preset_const <= c;
        preset_load <= 1'b1;
        repeat (4) @(posedge mclk);
        preset_load <= 1'b0;
        @(posedge mclk);
    endtask
    task t_format();
        wr(8'h10, 16'h8001);
        rd(8'h10);
        chk("unsigned", rdata, 32'h00008001);
        apb(1'b1, 12'h400, 32'h1);
        chk("format", signed_format, 1);
        rd(8'h10);
        chk("signed", rdata, 32'hFFFF8001);
        apb(1'b1, 12'h400, 32'h2);
        chk("running", program_running, 1);
    endtask
    task t_feed();
        present <= 1'b1;
        aux_coil_set <= 1'b1;
        foreach (ids[k]) begin
            rd(ids[k]);
            chk("feed", rdata, {24'h0, ids[k]});
        end
        wr(8'hC9, 16'h0000);
        rd(8'hC9);
        chk("owned", rdata, 32'hC9);
    endtask
    task t_absent();
        present <= 1'b0;
        aux_coil_set <= 1'b0;
        wr(8'hE4, 16'h1234);
        rd(8'hE4);
        chk("general", rdata, 32'h1234);
        wr(8'hE1, 16'h1234);
        rd(8'hE1);
        chk("standby", rdata, 32'h0);
        apb(1'b0, 12'h404, 32'h0);
        chk("slverr", rerr, 1);
    endtask
    task t_analog();
        for (int m = 0; m < 4; m++) begin
            wr(8'hD0, m[15:0]);
            chk("mode", analog_output_mode[1:0], m[1:0]);
        end
        preset_block_value <= 16'd3000;
        load(8'hD4, 1'b1, 16'h0);
        chk("aout", analog_output_channel[15:0], 16'd732);
        load(8'hD4, 1'b0, 16'd5000);
        chk("aout max", analog_output_channel[15:0], 16'd1000);
        load(8'hD0, 1'b0, 16'h3);
        chk("mode load", analog_output_mode[1:0], 2'h3);
        load(8'hD8, 1'b0, 16'h1);
        chk("hide", io_display_hiding, 16'h1);
    endtask
    task t_retain();
        wr(8'h65, 16'h00A5);
        wr(8'h10, 16'h0077);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        power_restore <= 1'b1;
        repeat (6) @(posedge mclk);
        power_restore <= 1'b0;
        @(posedge mclk);
        chk("run reset", program_running, 0);
        rd(8'h65);
        chk("kept", rdata, 32'hA5);
        rd(8'h10);
        chk("lost", rdata, 32'h0);
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_format();
        t_feed();
        t_absent();
        t_analog();
        t_retain();
        report_and_stop();
    end
endmodule // word_register_file_special_map_bench
